/* File: hdl/asp_defines.vh */
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
`define ASP_MODE_OFS        12'h000
`define ASP_STAT_OFS        12'h004
`define ASP_TXDATA_OFS      12'h008
`define ASP_RXDATA_OFS      12'h00C
`define ASP_BRG_OFS         12'h010
`define ASP_CTRL_OFS        12'h014
// Mode register fields
`define ASP_M_EN            15
`define ASP_M_SIDL          13
`define ASP_M_INFRARED_CODEC_ENABLE          12
`define ASP_M_RXINV         4
`define ASP_M_HISPD         3
`define ASP_M_PD_HI         2
`define ASP_M_PD_LO         1
`define ASP_M_STOP2         0
`define ASP_MODE_WMASK      16'hB01F
// Status register fields
`define ASP_S_TXI1          15
`define ASP_S_TXINV         14
`define ASP_S_TXI0          13
`define ASP_S_BRK           11
`define ASP_S_TXEN          10
`define ASP_S_TXBF          9
`define ASP_S_TX_SHIFTER_EMPTY          8
`define ASP_S_RXI_HI        7
`define ASP_S_RXI_LO        6
`define ASP_S_ADDRESS_DETECT_ENABLE         5
`define ASP_S_RECEIVER_IDLE         4
`define ASP_S_PARITY_ERROR          3
`define ASP_S_FRAMING_ERROR          2
`define ASP_S_OVERRUN_ERROR          1
`define ASP_S_RXDA          0
`define ASP_STAT_WMASK      16'hECE0
// Extra control register fields
`define ASP_C_IDLE          0
`define ASP_MODE_RST        16'h0000
`define ASP_STAT_RST        16'h0000
`define ASP_BRG_RST         16'h0000
`define ASP_FIFO_DEPTH      4
`define ASP_SAMP_HI         4
`define ASP_SAMP_LO         16
`define ASP_BREAK_BITS      4'hC
`endif

/* File: hdl/asp_serial_port.v */
// Asynchronous serial port with mode and status registers on an APB slave
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "asp_defines.vh"

module asp_serial_port #(
   parameter DEPTH = `ASP_FIFO_DEPTH
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        cpu_idle,
   input  wire        rx_pin,
   output reg         tx_pin,
   output wire        tx_pin_oe,
   output wire        port_owns_pins,
   output reg         tx_irq,
   output reg         rx_irq
);

   localparam S_IDLE = 4'b0001;
   localparam S_START = 4'b0010;
   localparam S_DATA = 4'b0100;
   localparam S_STOP = 4'b1000;

   reg  [15:0] mode_reg;
   reg  [15:0] stat_reg;
   reg  [15:0] brg_reg;
   reg  [31:0] prdata_reg;
   reg  [15:0] brg_cnt_reg;
   reg  [8:0]  tx_fifo_reg [0:DEPTH-1];
   reg  [10:0] rx_fifo_reg [0:DEPTH-1];
   reg  [2:0]  tx_cnt_reg;
   reg  [1:0]  tx_rd_reg;
   reg  [1:0]  tx_wr_reg;
   reg  [2:0]  rx_cnt_reg;
   reg  [1:0]  rx_rd_reg;
   reg  [1:0]  rx_wr_reg;
   reg  [3:0]  tx_st_reg;
   reg  [3:0]  rx_st_reg;
   reg  [3:0]  tx_ph_reg;
   reg  [3:0]  rx_ph_reg;
   reg  [3:0]  tx_bit_reg;
   reg  [3:0]  rx_bit_reg;
   reg  [13:0] tx_sh_reg;
   reg  [9:0]  rx_sh_reg;
   reg         tx_brk_reg;

   // ------------------------------------------------------------------
   // Configuration decode
   // ------------------------------------------------------------------
   wire       en = mode_reg[`ASP_M_EN];
   wire       run = en & ~(mode_reg[`ASP_M_SIDL] & cpu_idle);
   wire       infrared_codec_enable = mode_reg[`ASP_M_INFRARED_CODEC_ENABLE] & ~mode_reg[`ASP_M_HISPD];
   wire [1:0] pdsel = mode_reg[`ASP_M_PD_HI:`ASP_M_PD_LO];
   wire       nine = (pdsel == 2'b11);
   wire       par_on = (pdsel == 2'b10) | (pdsel == 2'b01);
   wire       par_odd = (pdsel == 2'b10);
   wire [3:0] ph_last = mode_reg[`ASP_M_HISPD] ? 4'h3 : 4'hF;
   wire [3:0] ph_mid = mode_reg[`ASP_M_HISPD] ? 4'h1 : 4'h7;
   wire       txen = stat_reg[`ASP_S_TXEN];
   wire       rx_lvl = rx_pin ^ mode_reg[`ASP_M_RXINV];
   wire       tick = run & (brg_cnt_reg == 16'h0000);

   wire       wr = psel & penable & pwrite;
   wire       rd = psel & penable & ~pwrite;
   wire       wr_mode = wr & (paddr == `ASP_MODE_OFS);
   wire       wr_stat = wr & (paddr == `ASP_STAT_OFS);
   wire       wr_tx = wr & (paddr == `ASP_TXDATA_OFS);
   wire       rd_rx = rd & (paddr == `ASP_RXDATA_OFS);
   wire       mapped = (paddr == `ASP_MODE_OFS) | (paddr == `ASP_STAT_OFS) |
                       (paddr == `ASP_TXDATA_OFS) | (paddr == `ASP_RXDATA_OFS) |
                       (paddr == `ASP_BRG_OFS) | (paddr == `ASP_CTRL_OFS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_reg;

   wire       tx_full = (tx_cnt_reg == DEPTH);
   wire       push_tx = wr_tx & ~tx_full & run & txen;
   wire       overrun_error_clr = wr_stat & stat_reg[`ASP_S_OVERRUN_ERROR] & ~pwdata[`ASP_S_OVERRUN_ERROR];
   wire [10:0] rx_head = rx_fifo_reg[rx_rd_reg];
   wire       pop_rx = rd_rx & (rx_cnt_reg != 3'd0);
   reg        rx_push;
   reg [10:0] rx_word;

   // ------------------------------------------------------------------
   // Registers and bus
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= `ASP_MODE_RST;
         stat_reg <= `ASP_STAT_RST;
         brg_reg <= `ASP_BRG_RST;
         prdata_reg <= 32'h00000000;
      end else begin
         if (wr_mode)
            mode_reg <= pwdata[15:0] & `ASP_MODE_WMASK;
         if (wr & (paddr == `ASP_BRG_OFS))
            brg_reg <= pwdata[15:0];
         if (wr_stat) begin
            stat_reg[15:13] <= pwdata[15:13];
            stat_reg[`ASP_S_TXEN] <= pwdata[`ASP_S_TXEN];
            stat_reg[7:5] <= pwdata[7:5];
            if (pwdata[`ASP_S_BRK])
               stat_reg[`ASP_S_BRK] <= 1'b1;
         end
         if (tx_brk_reg & (tx_st_reg == S_STOP) & tick & (tx_ph_reg == ph_last))
            stat_reg[`ASP_S_BRK] <= 1'b0;
         // Overrun set wins over a simultaneous software clear
         if (overrun_error_clr)
            stat_reg[`ASP_S_OVERRUN_ERROR] <= 1'b0;
         if (rx_push & (rx_cnt_reg == DEPTH))
            stat_reg[`ASP_S_OVERRUN_ERROR] <= 1'b1;
         if (!en) begin
            stat_reg[`ASP_S_TXEN] <= 1'b0;
            stat_reg[`ASP_S_BRK] <= 1'b0;
         end
         prdata_reg <= 32'h00000000;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `ASP_MODE_OFS: prdata_reg <= {16'h0000, mode_reg};
               `ASP_STAT_OFS: prdata_reg <= {16'h0000, stat_reg[15:13], 1'b0,
                  stat_reg[`ASP_S_BRK], txen, tx_full,
                  (tx_cnt_reg == 3'd0) & (tx_st_reg == S_IDLE),
                  stat_reg[7:5], rx_st_reg == S_IDLE,
                  rx_head[9] & (rx_cnt_reg != 3'd0),
                  rx_head[10] & (rx_cnt_reg != 3'd0),
                  stat_reg[`ASP_S_OVERRUN_ERROR], rx_cnt_reg != 3'd0};
               `ASP_RXDATA_OFS: prdata_reg <= {23'h000000, rx_head[8:0]};
               `ASP_BRG_OFS: prdata_reg <= {16'h0000, brg_reg};
               `ASP_CTRL_OFS: prdata_reg <= {31'h00000000, cpu_idle};
               default: prdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Bit-rate generator, one sample tick per divider wrap
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         brg_cnt_reg <= 16'h0000;
      else if (!run || brg_cnt_reg == 16'h0000)
         brg_cnt_reg <= brg_reg;
      else
         brg_cnt_reg <= brg_cnt_reg - 16'h0001;
   end

   // ------------------------------------------------------------------
   // Transmit buffer and shifter
   // ------------------------------------------------------------------
   wire [8:0] tx_head = tx_fifo_reg[tx_rd_reg];
   wire       tx_par = ^tx_head[7:0] ^ par_odd;
   wire       start_tx = tick & (tx_st_reg == S_IDLE) & txen & run &
                         ((tx_cnt_reg != 3'd0) | stat_reg[`ASP_S_BRK]);
   wire       tx_take = start_tx & ~stat_reg[`ASP_S_BRK];
   wire       tx_done = tick & (tx_st_reg == S_STOP) & (tx_ph_reg == ph_last) &
                        (tx_bit_reg == 4'd0);
   reg        tx_raw;
   integer    i;
   integer    j;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_reg <= 3'd0;
         tx_rd_reg <= 2'd0;
         tx_wr_reg <= 2'd0;
         tx_st_reg <= S_IDLE;
         tx_ph_reg <= 4'h0;
         tx_bit_reg <= 4'd0;
         tx_sh_reg <= 14'h0000;
         tx_brk_reg <= 1'b0;
         tx_irq <= 1'b0;
         for (i = 0; i < DEPTH; i = i + 1)
            tx_fifo_reg[i] <= 9'h000;
      end else begin
         tx_irq <= 1'b0;
         if (!txen || !en) begin
            tx_cnt_reg <= 3'd0;
            tx_rd_reg <= 2'd0;
            tx_wr_reg <= 2'd0;
            tx_st_reg <= S_IDLE;
            tx_brk_reg <= 1'b0;
         end else begin
            if (push_tx) begin
               tx_fifo_reg[tx_wr_reg] <= pwdata[8:0];
               tx_wr_reg <= tx_wr_reg + 2'd1;
            end
            tx_cnt_reg <= tx_cnt_reg + {2'b00, push_tx} - {2'b00, tx_take};
            if (tick)
               tx_ph_reg <= (tx_ph_reg == ph_last) ? 4'h0 : tx_ph_reg + 4'h1;
            case (tx_st_reg)
               S_IDLE: if (start_tx) begin
                  tx_st_reg <= S_START;
                  tx_ph_reg <= 4'h0;
                  tx_brk_reg <= stat_reg[`ASP_S_BRK];
                  if (stat_reg[`ASP_S_BRK]) begin
                     tx_sh_reg <= 14'h0000;
                     tx_bit_reg <= `ASP_BREAK_BITS;
                  end else begin
                     tx_rd_reg <= tx_rd_reg + 2'd1;
                     tx_sh_reg <= {5'h00, nine ? tx_head[8] : tx_par, tx_head[7:0]};
                     tx_bit_reg <= (nine | par_on) ? 4'd9 : 4'd8;
                     tx_irq <= (stat_reg[`ASP_S_TXI1] == 1'b0) & ~stat_reg[`ASP_S_TXI0] |
                               stat_reg[`ASP_S_TXI1] & ~stat_reg[`ASP_S_TXI0] &
                               (tx_cnt_reg == 3'd1);
                  end
               end
               S_START: if (tick && tx_ph_reg == ph_last)
                  tx_st_reg <= S_DATA;
               S_DATA: if (tick && tx_ph_reg == ph_last) begin
                  tx_sh_reg <= {1'b0, tx_sh_reg[13:1]};
                  if (tx_bit_reg == 4'd1) begin
                     tx_st_reg <= S_STOP;
                     tx_bit_reg <= mode_reg[`ASP_M_STOP2] ? 4'd1 : 4'd0;
                  end else
                     tx_bit_reg <= tx_bit_reg - 4'd1;
               end
               S_STOP: if (tick && tx_ph_reg == ph_last) begin
                  if (tx_bit_reg != 4'd0)
                     tx_bit_reg <= 4'd0;
                  else begin
                     tx_st_reg <= S_IDLE;
                     tx_brk_reg <= 1'b0;
                     tx_irq <= ~stat_reg[`ASP_S_TXI1] & stat_reg[`ASP_S_TXI0] &
                               (tx_cnt_reg == 3'd0);
                  end
               end
               default: tx_st_reg <= S_IDLE;
            endcase
         end
      end
   end

   // Line level before polarity: start drives active, data drives shifter bit 0, stop and idle drive idle
   always @* begin
      case (tx_st_reg)
         S_START: tx_raw = 1'b0;
         S_DATA:  tx_raw = tx_sh_reg[0];
         default: tx_raw = 1'b1;
      endcase
   end

   // Infrared mode pulses for the first three phases (0 to 2) of each zero bit
   wire ir_out = ~tx_raw & (tx_ph_reg < 4'h3);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tx_pin <= 1'b1;
      else if (infrared_codec_enable)
         tx_pin <= ir_out ^ stat_reg[`ASP_S_TXINV];
      else
         tx_pin <= tx_raw ^ stat_reg[`ASP_S_TXINV];
   end
   assign tx_pin_oe = en & txen;
   assign port_owns_pins = en;

   // ------------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------------
   wire rx_flush = overrun_error_clr | ~en;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_reg <= S_IDLE;
         rx_ph_reg <= 4'h0;
         rx_bit_reg <= 4'd0;
         rx_sh_reg <= 10'h000;
         rx_push <= 1'b0;
         rx_word <= 11'h000;
      end else begin
         rx_push <= 1'b0;
         if (rx_flush)
            rx_st_reg <= S_IDLE;
         else if (tick) begin
            rx_ph_reg <= (rx_ph_reg == ph_last) ? 4'h0 : rx_ph_reg + 4'h1;
            case (rx_st_reg)
               S_IDLE: if (!rx_lvl) begin
                  rx_st_reg <= S_START;
                  rx_ph_reg <= 4'h0;
               end
               S_START: if (rx_ph_reg == ph_mid) begin
                  rx_st_reg <= rx_lvl ? S_IDLE : S_DATA;
                  rx_bit_reg <= (nine | par_on) ? 4'd9 : 4'd8;
                  rx_sh_reg <= 10'h000;
               end
               S_DATA: if (rx_ph_reg == ph_mid) begin
                  rx_sh_reg <= {rx_lvl, rx_sh_reg[9:1]};
                  rx_bit_reg <= rx_bit_reg - 4'd1;
                  if (rx_bit_reg == 4'd1)
                     rx_st_reg <= S_STOP;
               end
               S_STOP: if (rx_ph_reg == ph_mid) begin
                  rx_st_reg <= S_IDLE;
                  // Realign the shift so bit 0 is data bit 0 in both widths
                  rx_word[8:0] <= nine ? rx_sh_reg[9:1] :
                                  (par_on ? {1'b0, rx_sh_reg[8:1]} : {1'b0, rx_sh_reg[9:2]});
                  rx_word[9] <= par_on & (^rx_sh_reg[9:1] ^ par_odd);
                  rx_word[10] <= ~rx_lvl;
                  rx_push <= ~(stat_reg[`ASP_S_ADDRESS_DETECT_ENABLE] & nine & ~rx_sh_reg[9]);
               end
               default: rx_st_reg <= S_IDLE;
            endcase
         end
      end
   end

   // Receive buffer; overrun drops the new character and keeps the queued ones
   wire rx_accept = rx_push & (rx_cnt_reg != DEPTH) & ~stat_reg[`ASP_S_OVERRUN_ERROR];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt_reg <= 3'd0;
         rx_rd_reg <= 2'd0;
         rx_wr_reg <= 2'd0;
         rx_irq <= 1'b0;
         for (j = 0; j < DEPTH; j = j + 1)
            rx_fifo_reg[j] <= 11'h000;
      end else if (rx_flush) begin
         rx_cnt_reg <= 3'd0;
         rx_rd_reg <= 2'd0;
         rx_wr_reg <= 2'd0;
         rx_irq <= 1'b0;
      end else begin
         if (rx_accept) begin
            rx_fifo_reg[rx_wr_reg] <= rx_word;
            rx_wr_reg <= rx_wr_reg + 2'd1;
         end
         if (pop_rx)
            rx_rd_reg <= rx_rd_reg + 2'd1;
         rx_cnt_reg <= rx_cnt_reg + {2'b00, rx_accept} - {2'b00, pop_rx};
         case (stat_reg[7:6])
            2'b11: rx_irq <= rx_accept & (rx_cnt_reg == 3'd3);
            2'b10: rx_irq <= rx_accept & (rx_cnt_reg == 3'd2);
            default: rx_irq <= rx_accept;
         endcase
      end
   end

endmodule // asp_serial_port

/* File: verification/asp_remote_node.sv */
// Remote serial node: frame sender on the receive line, frame catcher on the transmit line
`timescale 1ns/10ps
module asp_remote_node (
   input  wire pclk,
   input  wire tx_line,
   output reg  rx_line
);
   int         bt     = 4;
   bit         mon_on = 1'b0;
   logic [8:0] got_q[$];
   logic [8:0] c;
   initial rx_line = 1'b1;
   task automatic send(input [8:0] d, input int nb, input int par, input bit bad_par,
                       input bit bad_stop, input int nstop);
      bit p;
      p = ^d[7:0] ^ (par == 2) ^ bad_par;
      rx_line <= 1'b0;
      repeat (bt) @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         rx_line <= d[i];
         repeat (bt) @(posedge pclk);
      end
      if (par != 0) begin
         rx_line <= p;
         repeat (bt) @(posedge pclk);
      end
      rx_line <= ~bad_stop;
      // A broken stop stays low just past the sample point, so no false start follows
      repeat (bad_stop ? bt * 3 / 4 : bt * nstop) @(posedge pclk);
      if (bad_stop) begin
         rx_line <= 1'b1;
         repeat (bt * nstop) @(posedge pclk);
      end
   endtask
   always begin
      @(negedge tx_line);
      if (mon_on) begin
         c = 9'h000;
         repeat (bt / 2) @(posedge pclk);
         for (int i = 0; i < 8; i++) begin
            repeat (bt) @(posedge pclk);
            c[i] = tx_line;
         end
         repeat (bt) @(posedge pclk);
         got_q.push_back(c);
      end
   end
endmodule // asp_remote_node

/* File: verification/asp_serial_port_assertions.sv */
// Port-level assertions of the serial port, bound to its top module
`timescale 1ns/10ps
`include "asp_defines.vh"
module asp_port_checker #(
   parameter DEPTH = 4
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        tx_pin_oe,
   input wire        port_owns_pins,
   input wire        tx_irq,
   input wire        rx_irq
);
   // ----
   // Shadow of the mode register, taken from completed writes
   // ----
   logic [15:0] mode_sh;
   wire         acc     = psel && penable;
   wire         tx_on   = pwdata[`ASP_S_TXEN];
   wire         wr_mode = acc && pwrite && paddr == `ASP_MODE_OFS;
   wire         wr_stat = acc && pwrite && paddr == `ASP_STAT_OFS;
   wire         rd_mode = acc && !pwrite && paddr == `ASP_MODE_OFS;
   wire         rd_stat = acc && !pwrite && paddr == `ASP_STAT_OFS;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_sh <= 16'h0000;
      else if (wr_mode)
         mode_sh <= pwdata[15:0] & `ASP_MODE_WMASK;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----
   // Assertions
   // ----
   pins_follow_a: assert property (port_owns_pins == mode_sh[`ASP_M_EN])
      else $error("pin ownership differs from enable bit");
   oe_owned_a: assert property (tx_pin_oe |-> port_owns_pins)
      else $error("tx pin driven by a disabled port");
   oe_cause_a: assert property ($rose(tx_pin_oe) |-> $past(wr_stat || wr_mode))
      else $error("tx pin taken without a register write");
   txen_off_a: assert property (wr_stat && !tx_on |=> !tx_pin_oe)
      else $error("tx pin kept after transmit disable");
   txen_on_a: assert property (wr_stat && tx_on && mode_sh[`ASP_M_EN] |=> tx_pin_oe)
      else $error("tx pin not taken after transmit enable");
   tx_pulse_a: assert property (tx_irq |=> !tx_irq)
      else $error("transmit event longer than one cycle");
   rx_pulse_a: assert property (rx_irq |=> !rx_irq)
      else $error("receive event longer than one cycle");
   irq_gate_a: assert property (tx_irq || rx_irq |-> port_owns_pins)
      else $error("event from a disabled port");
   mode_rb_a: assert property (rd_mode |-> prdata[15:0] == mode_sh)
      else $error("mode readback differs from written value");
   busy_flags_a: assert property (rd_stat |-> !(prdata[`ASP_S_TXBF] && prdata[`ASP_S_TX_SHIFTER_EMPTY]))
      else $error("full and shifter empty both set");
   cover property (tx_irq);
   cover property (rx_irq);
   cover property (rd_stat && prdata[`ASP_S_OVERRUN_ERROR]);
endmodule // asp_port_checker

bind asp_serial_port asp_port_checker #(.DEPTH(DEPTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .tx_pin_oe(tx_pin_oe),
   .port_owns_pins(port_owns_pins), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

/* File: verification/async_serial_port_regs_bench.sv */
// Self-checking bench: register access, transmit and receive traffic of the serial port
`timescale 1ns/10ps
`include "asp_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module async_serial_port_regs_bench;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic        cpu_idle = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   wire  [31:0] prdata;
   wire         pready, pslverr, rx_pin, tx_pin, tx_pin_oe, port_owns_pins, tx_irq, rx_irq;
   wire         tx_line  = tx_pin_oe ? tx_pin : 1'b1;
   logic [15:0] r;
   logic        sl;
   int          errors = 0, check_count = 0, txc = 0, rxc = 0;
   logic [15:0] pm[3] = '{16'h800A, 16'h800C, 16'h8009};
   logic [15:0] pe[3] = '{16'h0001, 16'h0009, 16'h0005};
   asp_serial_port dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_idle(cpu_idle), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe),
      .port_owns_pins(port_owns_pins), .tx_irq(tx_irq), .rx_irq(rx_irq));
   asp_remote_node peer (.pclk(pclk), .tx_line(tx_line), .rx_line(rx_pin));
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      txc += (tx_irq === 1'b1);
      rxc += (rx_irq === 1'b1);
   end
   // ----
   // Bus tasks; read data and error are taken at the access edge
   // ----
   task automatic apb(input bit w, input [11:0] a, input [15:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      sl = pslverr;
      r = prdata[15:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic st(input [11:0] a, input [15:0] m, input [15:0] e, input string s, input int tr);
      int t;
      t = 0;
      do begin
         apb(1'b0, a, 16'h0000);
         t++;
      end while ((r & m) !== e && t < tr);
      `CHK(s, e, r & m)
   endtask
   task automatic lowrun(input int e, input string s);
      int n, k;
      n = 0;
      k = 0;
      while (tx_pin !== 1'b0 && n < 400) begin @(posedge pclk); n++; end
      while (tx_pin === 1'b0 && k < 400) begin @(posedge pclk); k++; end
      `CHK(s, e, k)
   endtask
   task automatic report_and_stop;
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #300000;
      errors++;
      $display("Error watchdog expected finish seen timeout");
      report_and_stop();
   end
   // ----
   // Test sequence
   // ----
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      st(`ASP_MODE_OFS, 16'hFFFF, 16'h0000, "mode reset", 1);
      st(`ASP_STAT_OFS, 16'hFFFF, 16'h0110, "status reset", 1);
      apb(1'b0, 12'h0FC, 16'h0000);
      `CHK("unmapped error", 1'b1, sl)
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, `ASP_MODE_OFS, 16'hA008 | 16'(k));
         st(`ASP_MODE_OFS, 16'hFFFF, 16'hA008 | 16'(k), "mode fields", 1);
      end
      apb(1'b1, `ASP_BRG_OFS, 16'h0000);
      apb(1'b1, `ASP_MODE_OFS, 16'h8008);
      apb(1'b1, `ASP_STAT_OFS, 16'h2400);
      `CHK("pins owned", 2'b11, {port_owns_pins, tx_pin_oe})
      txc = 0;
      peer.mon_on = 1'b1;
      for (int k = 0; k < 5; k++) apb(1'b1, `ASP_TXDATA_OFS, 16'h00A0 + 16'(k));
      st(`ASP_STAT_OFS, 16'h0300, 16'h0200, "tx full", 1);
      st(`ASP_STAT_OFS, 16'h0300, 16'h0100, "tx drained", 400);
      for (int k = 0; k < 5; k++) `CHK("tx char", 9'h0A0 + 9'(k), peer.got_q[k])
      `CHK("tx done events", 1, txc)
      peer.mon_on = 1'b0;
      apb(1'b1, `ASP_STAT_OFS, 16'h0C00);
      fork
         lowrun(52, "break low");
         apb(1'b1, `ASP_TXDATA_OFS, 16'h0000);
      join
      st(`ASP_STAT_OFS, 16'h0900, 16'h0100, "break done", 400);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `ASP_MODE_OFS, k ? 16'h8008 : 16'h8000);
         fork
            lowrun(k ? 36 : 144, "char low");
            apb(1'b1, `ASP_TXDATA_OFS, 16'h0000);
         join
         st(`ASP_STAT_OFS, 16'h0100, 16'h0100, "tx idle", 900);
      end
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `ASP_MODE_OFS, k[1] ? 16'h9000 : 16'h8000);
         apb(1'b1, `ASP_STAT_OFS, k[0] ? 16'h4400 : 16'h0400);
         @(negedge pclk);
         `CHK("tx idle level", k[1] ~^ k[0], tx_pin)
         @(posedge pclk);
      end
      apb(1'b1, `ASP_MODE_OFS, 16'h8008);
      for (int k = 0; k < 3; k++) apb(1'b1, `ASP_TXDATA_OFS, 16'h0011);
      apb(1'b1, `ASP_STAT_OFS, 16'h0000);
      st(`ASP_STAT_OFS, 16'h0700, 16'h0100, "tx abort", 1);
      `CHK("pin released", 1'b0, tx_pin_oe)
      apb(1'b1, `ASP_STAT_OFS, 16'h00C0);
      rxc = 0;
      for (int k = 0; k < 5; k++) peer.send(9'h030 + 9'(k), 8, 0, 1'b0, 1'b0, 1);
      st(`ASP_STAT_OFS, 16'h0013, 16'h0013, "overrun", 20);
      `CHK("rx full events", 1, rxc)
      st(`ASP_RXDATA_OFS, 16'h01FF, 16'h0030, "rx head", 1);
      apb(1'b1, `ASP_STAT_OFS, 16'h00C0);
      st(`ASP_STAT_OFS, 16'h0003, 16'h0000, "flushed", 1);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, `ASP_MODE_OFS, pm[k]);
         peer.send(9'h05A, 8, pm[k][2:1], k == 1, k == 2, k == 2 ? 2 : 1);
         peer.send(9'h03C, 8, pm[k][2:1], 1'b0, 1'b0, k == 2 ? 2 : 1);
         st(`ASP_STAT_OFS, 16'h000D, pe[k], "head flags", 20);
         st(`ASP_RXDATA_OFS, 16'h01FF, 16'h005A, "rx char", 1);
         st(`ASP_STAT_OFS, 16'h000D, 16'h0001, "next flags", 1);
         st(`ASP_RXDATA_OFS, 16'h01FF, 16'h003C, "rx next", 1);
      end
      apb(1'b1, `ASP_MODE_OFS, 16'hA008);
      cpu_idle <= 1'b1;
      peer.send(9'h077, 8, 0, 1'b0, 1'b0, 1);
      st(`ASP_STAT_OFS, 16'h0001, 16'h0000, "idle halt", 1);
      cpu_idle <= 1'b0;
      apb(1'b1, `ASP_MODE_OFS, 16'h800E);
      apb(1'b1, `ASP_STAT_OFS, 16'h0020);
      peer.send(9'h055, 9, 0, 1'b0, 1'b0, 1);
      peer.send(9'h1AA, 9, 0, 1'b0, 1'b0, 1);
      st(`ASP_STAT_OFS, 16'h0001, 16'h0001, "rx ready", 20);
      st(`ASP_RXDATA_OFS, 16'h01FF, 16'h01AA, "address char", 1);
      st(`ASP_STAT_OFS, 16'h0001, 16'h0000, "no data char", 1);
      report_and_stop();
   end
endmodule // async_serial_port_regs_bench
